// [bench/lid_regs_tb.sv]
// Self-checking bench for the identifier and transmit buffer slice.
// Assumes the serialiser model on the byte stream; header inputs come from here.
`timescale 1ns/10ps
module lid_regs_tb;
	logic mclk_i;
	logic reset_i;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic commander;
	logic fsel;
	logic [7:0] rxs;
	logic hdrv;
	logic perr;
	logic [7:0] mrx;
	logic [7:0] mtx;
	logic rxm;
	logic txm;
	logic hst;
	logic [7:0] hid;
	logic rsp;
	logic [7:0] txs;
	logic txv;
	logic txr;
	logic slow;
	logic [7:0] exp_rid;
	int fails;
	int total_checks;

	lid_regs #(.FIFO_DEPTH(32)) uut (.mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(1'b1), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .commander_i(commander),
		.filter_source_select_i(fsel), .rx_shift_reg_i(rxs), .hdr_id_valid_i(hdrv), .id_parity_err_i(perr),
		.rx_match_mask_i(mrx), .tx_match_mask_i(mtx), .rx_match_o(rxm), .tx_match_o(txm),
		.header_start_o(hst), .header_ident_o(hid), .resp_start_o(rsp), .tx_shift_reg_o(txs),
		.tx_valid_o(txv), .tx_ready_i(txr));
	lid_serial_model u_ser (.mclk_i(mclk_i), .reset_i(reset_i), .slow_i(slow), .tx_shift_reg_i(txs),
		.tx_valid_i(txv), .tx_ready_o(txr));

	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		@(posedge mclk_i);
		while (hready !== 1'b1) @(posedge mclk_i);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk_i);
		while (hready !== 1'b1) @(posedge mclk_i);
		q = hrdata;
	endtask

	task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb_xfer(1'b1, a, d, q);
	endtask

	// Pulse seen in either of the two cycles after a commit
	task automatic seen2(ref logic s, output logic r);
		#1;
		r = s;
		@(posedge mclk_i);
		#1;
		r = r | s;
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_reset();
		logic [31:0] d;
		ahb_xfer(1'b0, 8'h00, 32'h0, d);
		chk(d, 32'h0);
		ahb_xfer(1'b0, 8'h04, 32'h0, d);
		chk(d, 32'h0);
		ahb_xfer(1'b0, 8'h08, 32'h0, d);
		chk(d, 32'h0);
		ahb_xfer(1'b0, 8'h3c, 32'h0, d);
		chk(d, 32'h0);
		ahb_xfer(1'b0, 8'h0c, 32'h0, d);
		chk(d, {29'h0, lid_pkg::RESP_LEN_RESET});
		ahb_xfer(1'b0, 8'h10, 32'h0, d);
		chk(d, 32'h0);
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic t_commander();
		logic [31:0] d;
		logic p;
		commander <= 1'b1;
		ahb_write(8'h00, 32'hffff_ffff);
		chk({31'h0, hresp}, 32'h0);
		seen2(hst, p);
		chk({p, hid}, {1'b1, 8'hff});
		@(posedge mclk_i);
		commander <= 1'b0;
		ahb_xfer(1'b0, 8'h00, 32'h0, d);
		chk(d, {8'h00, exp_rid, 16'hffff});
	endtask

	task automatic t_hdr(input logic sel, input logic [7:0] msg, input logic [7:0] cmp, input logic [7:0] rxb,
		input logic [7:0] mr, input logic [7:0] mt, input logic pe);
		logic [7:0] f;
		logic er;
		logic et;
		logic p;
		logic [31:0] d;
		f = sel ? cmp : msg;
		er = !pe && ((rxb ^ f) & ~mr) == 8'h00;
		et = !pe && ((rxb ^ f) & ~mt) == 8'h00;
		ahb_write(8'h00, {16'h0, cmp, msg});
		seen2(hst, p);
		chk(p, 1'b0);
		@(posedge mclk_i);
		fsel <= sel;
		rxs <= rxb;
		mrx <= mr;
		mtx <= mt;
		perr <= pe;
		hdrv <= 1'b1;
		@(posedge mclk_i);
		hdrv <= 1'b0;
		#1;
		chk({rxm, txm}, {er, et});
		if (er || et) begin
			exp_rid = rxb;
		end
		@(posedge mclk_i);
		ahb_xfer(1'b0, 8'h00, 32'h0, d);
		chk(d, {8'h00, exp_rid, cmp, msg});
	endtask

	task automatic t_tx(input logic sl, input logic [2:0] len, input logic [31:0] lo, input logic [31:0] hi);
		logic [7:0] e[8];
		logic p;
		logic [31:0] d;
		int n;
		{e[0], e[1], e[2], e[3]} = lo;
		{e[4], e[5], e[6], e[7]} = hi;
		n = len + 1;
		u_ser.got.delete();
		slow <= sl;
		ahb_write(8'h0c, {29'h0, len});
		ahb_write(8'h08, hi);
		ahb_write(8'h04, lo);
		seen2(rsp, p);
		chk(p, 1'b1);
		for (int k = 0; k < 300 && u_ser.got.size() < n; k++) @(posedge mclk_i);
		repeat (20) @(posedge mclk_i);
		chk(u_ser.got.size(), n);
		for (int i = 0; i < n; i++) begin
			chk(u_ser.got[i], e[i]);
		end
		ahb_xfer(1'b0, 8'h04, 32'h0, d);
		chk(d, lo);
		ahb_xfer(1'b0, 8'h08, 32'h0, d);
		chk(d, hi);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Whole run needs well under two thousand cycles
	initial begin
		#500000;
		fails++;
		final_report();
	end

	initial begin
		reset_i = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		commander = 1'b0;
		fsel = 1'b0;
		rxs = 8'h00;
		hdrv = 1'b0;
		perr = 1'b0;
		mrx = 8'h00;
		mtx = 8'h00;
		slow = 1'b0;
		exp_rid = 8'h00;
		fails = 0;
		total_checks = 0;
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		t_reset();
		t_commander();
		t_hdr(1'b0, 8'h3c, 8'h55, 8'h3c, 8'h00, 8'h00, 1'b0);
		t_hdr(1'b1, 8'h3c, 8'h55, 8'h3c, 8'h00, 8'h00, 1'b0);
		t_hdr(1'b1, 8'h3c, 8'h55, 8'h54, 8'h01, 8'h00, 1'b0);
		t_hdr(1'b0, 8'h3c, 8'h55, 8'h3c, 8'h00, 8'h00, 1'b1);
		t_hdr(1'b0, 8'h3c, 8'h55, 8'hbc, 8'h00, 8'h80, 1'b0);
		t_tx(1'b0, 3'h7, 32'h0123_4567, 32'h89ab_cdef);
		t_tx(1'b1, 3'h3, 32'hfedc_ba98, 32'h7654_3210);
		t_tx(1'b1, 3'h0, 32'ha5c3_0000, 32'h0000_0000);
		final_report();
	end
endmodule

// [bench/lid_serial_model.sv]
// Serialiser stand-in that takes transmit bytes and can stall.
// Assumes the slice's clock and reset; accepted bytes go into a queue.
`timescale 1ns/10ps
module lid_serial_model (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic slow_i,
	input wire logic [7:0] tx_shift_reg_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o
);
	logic [1:0] cnt;
	logic [7:0] got[$];
	// Slow mode accepts one cycle in four, so the FIFO backs up
	always @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt <= 2'h0;
			tx_ready_o <= 1'b0;
		end else begin
			cnt <= cnt + 2'h1;
			tx_ready_o <= !slow_i || cnt == 2'h3;
			if (tx_valid_i && tx_ready_o) begin
				got.push_back(tx_shift_reg_i);
			end
		end
	end
endmodule

// [src/lid_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/10ps
module lid_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	lid_stream_if.consumer wr_s,
	lid_stream_if.producer rd_s,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	wire push = wr_s.valid && wr_s.ready;
	wire pop = rd_s.valid && rd_s.ready;
	assign wr_s.ready = (count != FULL);
	assign rd_s.valid = (count != '0);
	assign rd_s.data = mem[rptr];
	assign level_o = count;
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	for (genvar g = 0; g < DEPTH; g++) begin : g_entry
		always_ff @(posedge mclk_i or posedge reset_i) begin
			if (reset_i)
				mem[g] <= '0;
			else if (push && wptr == AW'(g))
				mem[g] <= wr_s.data;
		end
	end
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wptr <= wptr + 1'b1;
			if (pop)
				rptr <= rptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
	a_fifo_count: assert property (@(posedge mclk_i) disable iff (reset_i)
		push && !pop |=> count == $past(count) + 1'b1)
		else $error("fifo count did not rise on push");
endmodule

// [src/lid_pkg.sv]
// Constants for the identifier and transmit buffer register slice.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package lid_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_IDENT = 8'h00;
	localparam logic [7:0] OFF_TXLO = 8'h04;
	localparam logic [7:0] OFF_TXHI = 8'h08;
	localparam logic [7:0] OFF_CTRL = 8'h0c;
	localparam logic [7:0] OFF_STAT = 8'h10;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int RXID_LSB = 16;
	localparam int CMPID_LSB = 8;
	localparam int MSGID_LSB = 0;
	localparam int RESP_LEN_LSB = 0;
	localparam int RESP_LEN_W = 3;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LEVEL_LSB = 8;
	// ----------------------------------------
	// Reset values and sizes
	// ----------------------------------------
	localparam logic [31:0] IDENT_RESET = 32'h0000_0000;
	localparam logic [31:0] TXBUF_RESET = 32'h0000_0000;
	localparam logic [2:0] RESP_LEN_RESET = 3'h7;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_LOAD = 1'b1
	} lid_seq_t;
endpackage

// [src/lid_regs.sv]
// Identifier and transmit buffer registers of the serial bus controller.
// Assumes an AHB-Lite master and a framing engine that drives the header and shift inputs.
`timescale 1ns/10ps
// Overview of operation
// RULE1 - Capture received identifier on clean matched header
// RULE2 - Compare header identifier to decide response action
// RULE3 - Commander identifier write starts header transmission
// RULE4 - Message identifier filters when source select clear
// RULE5 - Writing byte zero starts response transmission
// RULE6 - Each buffer byte goes to shift register
// RULE7 - Bytes packed most significant first per register
// RULE8 - Identifier top byte reads zero, writes ignored
// RULE9 - Set mask bit excludes bit from compare
// RULE10 - Send bytes ascending from zero to length
module lid_regs #(
	parameter int FIFO_DEPTH = lid_pkg::FIFO_DEPTH
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic commander_i,
	input wire logic filter_source_select_i,
	input wire logic [7:0] rx_shift_reg_i,
	input wire logic hdr_id_valid_i,
	input wire logic id_parity_err_i,
	input wire logic [7:0] rx_match_mask_i,
	input wire logic [7:0] tx_match_mask_i,
	output logic rx_match_o,
	output logic tx_match_o,
	output logic header_start_o,
	output logic [7:0] header_ident_o,
	output logic resp_start_o,
	output logic [7:0] tx_shift_reg_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] received_ident;
	logic [7:0] responder_compare_ident;
	logic [7:0] message_ident;
	logic [31:0] tx_bytes_low_reg;
	logic [31:0] tx_bytes_high_reg;
	logic [2:0] resp_len_m1;
	lid_pkg::lid_seq_t seq_state;
	logic [2:0] byte_idx;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic rd_pend;
	logic [7:0] rd_addr;
	logic [LW-1:0] fifo_level;
	lid_stream_if #(.W(lid_pkg::BYTE_W)) fill_s();
	lid_stream_if #(.W(lid_pkg::BYTE_W)) drain_s();
	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire addr_phase = hsel_i && htrans_i[1] && hready_i;
	wire word_ok = (hsize_i == lid_pkg::HSIZE_WORD);
	wire take_wr = addr_phase && hwrite_i && word_ok;
	wire take_rd = addr_phase && !hwrite_i;
	wire wr_ident = wr_pend && (wr_addr == lid_pkg::OFF_IDENT);
	wire wr_txlo = wr_pend && (wr_addr == lid_pkg::OFF_TXLO);
	wire wr_txhi = wr_pend && (wr_addr == lid_pkg::OFF_TXHI);
	wire wr_ctrl = wr_pend && (wr_addr == lid_pkg::OFF_CTRL);
	wire [31:0] ident_word;
	wire [31:0] ctrl_word;
	wire [31:0] stat_word;
	logic [31:0] rd_mux;
	// Top byte left as constant zero [RULE8]
	assign ident_word = {8'h00, received_ident, responder_compare_ident, message_ident};
	assign ctrl_word = {29'h0000_0000, resp_len_m1};
	assign stat_word = {{(24-LW){1'b0}}, fifo_level, 7'h00, (seq_state == lid_pkg::SEQ_LOAD)};
	always_comb begin
		if (rd_addr == lid_pkg::OFF_IDENT)
			rd_mux = ident_word;
		else if (rd_addr == lid_pkg::OFF_TXLO)
			rd_mux = tx_bytes_low_reg;
		else if (rd_addr == lid_pkg::OFF_TXHI)
			rd_mux = tx_bytes_high_reg;
		else if (rd_addr == lid_pkg::OFF_CTRL)
			rd_mux = ctrl_word;
		else if (rd_addr == lid_pkg::OFF_STAT)
			rd_mux = stat_word;
		else
			rd_mux = 32'h0000_0000;
	end
	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// Reads take one wait state so a read right after a write sees the new value
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			rd_pend <= 1'b0;
			rd_addr <= 8'h00;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			wr_pend <= take_wr;
			if (take_wr)
				wr_addr <= haddr_i[7:0];
			if (take_rd) begin
				rd_pend <= 1'b1;
				rd_addr <= haddr_i[7:0];
				hreadyout_o <= 1'b0;
			end else if (rd_pend) begin
				rd_pend <= 1'b0;
				hrdata_o <= rd_mux;
				hreadyout_o <= 1'b1;
			end
			hresp_o <= lid_pkg::HRESP_OKAY[0];
		end
	end
	// ----------------------------------------
	// Identifier register
	// ----------------------------------------
	wire [7:0] filter_ident = filter_source_select_i ? responder_compare_ident : message_ident; // [RULE4]
	wire [7:0] id_diff = rx_shift_reg_i ^ filter_ident;
	wire rx_hit = ((id_diff & ~rx_match_mask_i) == 8'h00); // [RULE2] [RULE9]
	wire tx_hit = ((id_diff & ~tx_match_mask_i) == 8'h00); // [RULE2] [RULE9]
	wire capture_id = hdr_id_valid_i && !id_parity_err_i && (rx_hit || tx_hit);
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			received_ident <= lid_pkg::IDENT_RESET[lid_pkg::RXID_LSB+:8];
			responder_compare_ident <= lid_pkg::IDENT_RESET[lid_pkg::CMPID_LSB+:8];
			message_ident <= lid_pkg::IDENT_RESET[lid_pkg::MSGID_LSB+:8];
		end else begin
			if (capture_id)
				received_ident <= rx_shift_reg_i; // [RULE1]
			if (wr_ident) begin
				responder_compare_ident <= hwdata_i[lid_pkg::CMPID_LSB+:8];
				message_ident <= hwdata_i[lid_pkg::MSGID_LSB+:8];
			end
		end
	end
	// Match results are registered pulses, one per header
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			rx_match_o <= 1'b0;
			tx_match_o <= 1'b0;
		end else begin
			rx_match_o <= hdr_id_valid_i && !id_parity_err_i && rx_hit; // [RULE2]
			tx_match_o <= hdr_id_valid_i && !id_parity_err_i && tx_hit; // [RULE2]
		end
	end
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			header_start_o <= 1'b0;
			header_ident_o <= 8'h00;
		end else begin
			header_start_o <= wr_ident && commander_i; // [RULE3]
			if (wr_ident && commander_i)
				header_ident_o <= hwdata_i[lid_pkg::MSGID_LSB+:8];
		end
	end
	// ----------------------------------------
	// Transmit buffers and control
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			tx_bytes_low_reg <= lid_pkg::TXBUF_RESET;
			tx_bytes_high_reg <= lid_pkg::TXBUF_RESET;
			resp_len_m1 <= lid_pkg::RESP_LEN_RESET;
		end else begin
			if (wr_txlo)
				tx_bytes_low_reg <= hwdata_i;
			if (wr_txhi)
				tx_bytes_high_reg <= hwdata_i;
			if (wr_ctrl)
				resp_len_m1 <= hwdata_i[lid_pkg::RESP_LEN_LSB+:lid_pkg::RESP_LEN_W];
		end
	end
	// ----------------------------------------
	// Response sequencer
	// ----------------------------------------
	// Byte 0 sits at the top of the low register, byte 7 at the bottom of the high one
	wire [63:0] tx_all = {tx_bytes_low_reg, tx_bytes_high_reg}; // [RULE7]
	wire [5:0] byte_sel = {~byte_idx, 3'h0};
	wire last_byte = (byte_idx == resp_len_m1);
	wire fill_go = (seq_state == lid_pkg::SEQ_LOAD) && fill_s.ready;
	assign fill_s.valid = (seq_state == lid_pkg::SEQ_LOAD);
	assign fill_s.data = tx_all[byte_sel+:8]; // [RULE7]
	lid_pkg::lid_seq_t next_state;
	logic [2:0] next_idx;
	// A fresh byte 0 write restarts the response from the top
	always_comb begin
		next_state = seq_state;
		next_idx = byte_idx;
		case (seq_state)
			lid_pkg::SEQ_IDLE: begin
				next_idx = 3'h0;
			end
			lid_pkg::SEQ_LOAD: begin
				if (fill_go) begin
					next_idx = byte_idx + 3'h1; // [RULE10]
					if (last_byte)
						next_state = lid_pkg::SEQ_IDLE; // [RULE10]
				end
			end
			default: begin
				next_state = lid_pkg::SEQ_IDLE;
			end
		endcase
		if (wr_txlo) begin
			next_state = lid_pkg::SEQ_LOAD; // [RULE5]
			next_idx = 3'h0;
		end
	end
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			seq_state <= lid_pkg::SEQ_IDLE;
			byte_idx <= 3'h0;
			resp_start_o <= 1'b0;
		end else begin
			seq_state <= next_state;
			byte_idx <= next_idx;
			resp_start_o <= wr_txlo; // [RULE5]
		end
	end
	// ----------------------------------------
	// FIFO and shift register hand-off
	// ----------------------------------------
	// Depth absorbs a slow serialiser; the sequencer stalls when it fills
	lid_fifo #(.W(lid_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.wr_s(fill_s),
		.rd_s(drain_s),
		.level_o(fifo_level)
	);
	wire out_free = !tx_valid_o || tx_ready_i;
	assign drain_s.ready = out_free;
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			tx_shift_reg_o <= 8'h00;
			tx_valid_o <= 1'b0;
		end else if (out_free) begin
			tx_valid_o <= drain_s.valid;
			if (drain_s.valid)
				tx_shift_reg_o <= drain_s.data; // [RULE6]
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_td0_write;
		wr_txlo;
	endsequence
	sequence s_first_push;
		s_td0_write ##1 (fill_s.valid && fill_s.ready);
	endsequence
	a_rxid_capture: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE1]
		capture_id |=> received_ident == $past(rx_shift_reg_i))
		else $error("received identifier not captured");
	a_rxid_parity: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE1]
		hdr_id_valid_i && id_parity_err_i |=> $stable(received_ident))
		else $error("received identifier changed on parity error");
	a_match_mask: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE9]
		hdr_id_valid_i && !id_parity_err_i && ((id_diff & ~tx_match_mask_i) != 8'h00) |=> !tx_match_o)
		else $error("tx match despite unmasked mismatch");
	a_filter_src: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE4]
		hdr_id_valid_i && !id_parity_err_i && !filter_source_select_i && rx_match_mask_i == 8'h00
		&& rx_shift_reg_i == message_ident |=> rx_match_o)
		else $error("message identifier filter missed");
	a_match_result: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE2]
		!hdr_id_valid_i |=> !rx_match_o && !tx_match_o)
		else $error("match without header");
	a_header_start: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE3]
		wr_ident && commander_i |=> header_start_o && header_ident_o == $past(hwdata_i[7:0]))
		else $error("header not started on identifier write");
	a_resp_start: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE5]
		s_td0_write |=> seq_state == lid_pkg::SEQ_LOAD && byte_idx == 3'h0 && resp_start_o)
		else $error("response not started on byte zero write");
	a_byte_order: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE7]
		s_first_push |-> fill_s.data == tx_bytes_low_reg[31:24])
		else $error("first byte is not byte zero");
	a_resp_len: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE10]
		fill_go && last_byte && !wr_txlo |=> seq_state == lid_pkg::SEQ_IDLE
		##1 (seq_state == lid_pkg::SEQ_IDLE || $past(wr_txlo)))
		else $error("response ran past its length");
	a_shift_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE6]
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_shift_reg_o))
		else $error("shift byte dropped while stalled");
	a_reserved_zero: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE8]
		rd_pend && rd_addr == lid_pkg::OFF_IDENT |=> hrdata_o[31:24] == 8'h00 && hreadyout_o)
		else $error("reserved identifier byte not zero");
endmodule

// [src/lid_stream_if.sv]
// Valid/ready byte stream between the register slice and its FIFO.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface lid_stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport producer(output data, output valid, input ready);
	modport consumer(input data, input valid, output ready);
endinterface
